// ===== dcs_cmd_decode.v
// dcs_cmd_decode.v: turns command pins into an operation code
// assumes: pins are sampled on the rising edge by the caller
`timescale 1ns/1ps
`include "dcs_consts.vh"
module dcs_cmd_decode (
    input wire csN,
    input wire rasN,
    input wire casN,
    input wire weN,
    output reg [3:0] opCode
);
    always @* begin
        if (csN) begin
            opCode = `DCS_OP_DESEL;
        end else begin
            case ({rasN, casN, weN})
                3'h7: opCode = `DCS_OP_NOP;
                3'h3: opCode = `DCS_OP_ACT;
                3'h2: opCode = `DCS_OP_PRE;
                3'h5: opCode = `DCS_OP_READ;
                3'h4: opCode = `DCS_OP_WRITE;
                3'h1: opCode = `DCS_OP_REF;
                3'h0: opCode = `DCS_OP_MRS;
                default: opCode = `DCS_OP_NOP;
            endcase
        end
    end
endmodule

// ===== dcs_consts.vh
// dcs_consts.vh: constants for the cke/command state tracker
// assumes: included by dcs_state_tracker.v and dcs_cmd_decode.v
`ifndef DCS_CONSTS_VH
`define DCS_CONSTS_VH
// operation codes decoded from {csN, rasN, casN, weN}
`define DCS_CMD_W 4
`define DCS_OP_W 4
`define DCS_OP_DESEL 4'h0
`define DCS_OP_NOP 4'h1
`define DCS_OP_ACT 4'h2
`define DCS_OP_PRE 4'h3
`define DCS_OP_READ 4'h4
`define DCS_OP_WRITE 4'h5
`define DCS_OP_REF 4'h6
`define DCS_OP_MRS 4'h7
// states
`define DCS_ST_W 4
`define DCS_ST_IDLE 4'h0
`define DCS_ST_ACTIVE 4'h1
`define DCS_ST_READ 4'h2
`define DCS_ST_WRITE 4'h3
`define DCS_ST_PRE_PD 4'h4
`define DCS_ST_ACT_PD 4'h5
`define DCS_ST_SELF_REF 4'h6
`define DCS_ST_REF 4'h7
`define DCS_ST_MRS 4'h8
`define DCS_ST_PRECH 4'h9
// burst length in clocks (two beats per clock, burst of four)
`define DCS_BURST_CLKS 3'h2
`define DCS_BURST_W 3
// data path width and mask lanes
`define DCS_DQ_W 16
`define DCS_DM_W 2
`define DCS_LANE_W 8
// min_cke_hold in edges
`define DCS_CKE_HOLD 2'h3
`define DCS_HOLD_W 2
// self_refresh_exit_read_delay in clocks
`define DCS_XS_READ_CLKS 8'hc8
`define DCS_XS_W 8
`endif

// ===== dcs_ctrl_model.sv
// controller stand-in: turns a requested operation into command pins
// assumes: requests change just after a rising edge of clk
`timescale 1ns/1ps
`include "dcs_consts.vh"
module dcs_ctrl_model (
    input wire clk,
    input wire [3:0] reqOp,
    input wire reqCke,
    output wire cke,
    output reg csN, rasN, casN, weN
);
reg junk_ff = 1'b0;
reg ckeLast_ff = 1'b0;
// the bench keeps each cke level for three or more edges, except one single-edge low pulse that checks seqError
assign cke = reqCke;
always @(posedge clk) begin
    junk_ff <= ~junk_ff;
    ckeLast_ff <= cke;
end
always @* begin
    // don't-care pins float: a changing pattern, never a stale command
    if (!cke && !ckeLast_ff)
        {csN, rasN, casN, weN} = {4{junk_ff}};
    else if (cke != ckeLast_ff && !(reqOp == `DCS_OP_REF && !cke))
        {csN, rasN, casN, weN} = 4'h7;
    else case (reqOp)
        `DCS_OP_DESEL: {csN, rasN, casN, weN} = {1'b1, {3{junk_ff}}};
        `DCS_OP_NOP: {csN, rasN, casN, weN} = 4'h7;
        `DCS_OP_ACT: {csN, rasN, casN, weN} = 4'h3;
        `DCS_OP_PRE: {csN, rasN, casN, weN} = 4'h2;
        `DCS_OP_READ: {csN, rasN, casN, weN} = 4'h5;
        `DCS_OP_WRITE: {csN, rasN, casN, weN} = 4'h4;
        `DCS_OP_REF: {csN, rasN, casN, weN} = 4'h1;
        default: {csN, rasN, casN, weN} = 4'h0;
    endcase
end
endmodule

// ===== dcs_state_tracker.v
// dcs_state_tracker.v: device-side cke and command state tracker
// assumes: one clock, all pins synchronous to clk, sync active-high reset
//
// Notes on behaviour
// - transitions use cke at this edge and the previous edge.
// - self refresh entered only from idle, cke falling with refresh.
// - power down from idle is precharge, from active is active power down.
// - odt does not steer states; termination off in self refresh.
// - commands ignored in self refresh and power down while cke stays low.
// - mask low writes the beat, mask high blocks it.
// - idle: act, pre, ref, mrs accepted; read and write illegal.
// - banks active: read, write, pre accepted; act, ref, mrs illegal.
// - bursts: nop or deselect continues, same-kind command interrupts, rest illegal.
`timescale 1ns/1ps
`include "dcs_consts.vh"
module dcs_state_tracker (
    input wire clk,
    input wire reset,
    input wire clkEn,
    input wire cke,
    input wire csN,
    input wire rasN,
    input wire casN,
    input wire weN,
    input wire odt,
    input wire odtEnabled,
    input wire wrBeatValid,
    input wire [15:0] wrData,
    input wire [1:0] wrMask,
    output reg [3:0] devState,
    output reg illegalCmd,
    output reg seqError,
    output reg termActive,
    output reg wrStrobe,
    output reg [15:0] wrDataOut,
    output reg [1:0] wrLaneEn,
    output reg readAllowed
);
    // ------------------------------------------------------------
    // command decode
    // ------------------------------------------------------------
    wire [3:0] opCode;
    dcs_cmd_decode u_dec (
        .csN(csN),
        .rasN(rasN),
        .casN(casN),
        .weN(weN),
        .opCode(opCode)
    );

    function isQuiet;
        input [3:0] op;
        begin
            isQuiet = (op == `DCS_OP_DESEL) || (op == `DCS_OP_NOP);
        end
    endfunction

    // ------------------------------------------------------------
    // state registers
    // ------------------------------------------------------------
    reg [3:0] state_ff;
    reg [3:0] nxt_state;
    reg ckePrev_ff;
    reg rowOpen_ff;
    reg nxt_rowOpen;
    reg [2:0] burst_ff;
    reg [2:0] nxt_burst;
    reg [1:0] ckeHold_ff;
    reg [7:0] xsCount_ff;
    reg illegal;
    reg seqErr;
    wire ckeFall = ckePrev_ff && !cke;
    wire ckeRise = !ckePrev_ff && cke;
    wire inLowPower = (state_ff == `DCS_ST_PRE_PD) ||
        (state_ff == `DCS_ST_ACT_PD) || (state_ff == `DCS_ST_SELF_REF);

    // ------------------------------------------------------------
    // next state
    // ------------------------------------------------------------
    always @* begin
        nxt_state = state_ff;
        nxt_rowOpen = rowOpen_ff;
        nxt_burst = (burst_ff != 3'h0) ? burst_ff - 3'h1 : 3'h0;
        illegal = 1'b0;
        seqErr = 1'b0;
        if (inLowPower) begin
            // commands are don't-care while cke stays low, even floating ones
            if (ckeRise) begin
                if (!isQuiet(opCode)) begin
                    seqErr = 1'b1;
                end
                nxt_state = rowOpen_ff ? `DCS_ST_ACTIVE : `DCS_ST_IDLE;
            end
        end else if (!ckePrev_ff) begin
            seqErr = 1'b1;
        end else if (ckeFall) begin
            if (state_ff == `DCS_ST_IDLE && opCode == `DCS_OP_REF) begin
                nxt_state = `DCS_ST_SELF_REF;
            end else if (!isQuiet(opCode)) begin
                seqErr = 1'b1;
            end else if (state_ff == `DCS_ST_IDLE) begin
                nxt_state = `DCS_ST_PRE_PD;
            end else if (state_ff == `DCS_ST_ACTIVE) begin
                nxt_state = `DCS_ST_ACT_PD;
            end else begin
                seqErr = 1'b1;
            end
        end else begin
            case (state_ff)
                `DCS_ST_IDLE: begin
                    case (opCode)
                        `DCS_OP_ACT: begin
                            nxt_state = `DCS_ST_ACTIVE;
                            nxt_rowOpen = 1'b1;
                        end
                        `DCS_OP_PRE: nxt_state = `DCS_ST_PRECH;
                        `DCS_OP_REF: nxt_state = `DCS_ST_REF;
                        `DCS_OP_MRS: nxt_state = `DCS_ST_MRS;
                        `DCS_OP_READ, `DCS_OP_WRITE: illegal = 1'b1;
                        default: nxt_state = `DCS_ST_IDLE;
                    endcase
                end
                `DCS_ST_ACTIVE: begin
                    case (opCode)
                        `DCS_OP_READ: begin
                            nxt_state = `DCS_ST_READ;
                            nxt_burst = `DCS_BURST_CLKS;
                        end
                        `DCS_OP_WRITE: begin
                            nxt_state = `DCS_ST_WRITE;
                            nxt_burst = `DCS_BURST_CLKS;
                        end
                        `DCS_OP_PRE: begin
                            nxt_state = `DCS_ST_PRECH;
                            nxt_rowOpen = 1'b0;
                        end
                        `DCS_OP_ACT, `DCS_OP_REF, `DCS_OP_MRS:
                            illegal = 1'b1;
                        default: nxt_state = `DCS_ST_ACTIVE;
                    endcase
                end
                `DCS_ST_READ, `DCS_ST_WRITE: begin
                    if ((state_ff == `DCS_ST_READ &&
                         opCode == `DCS_OP_READ) ||
                        (state_ff == `DCS_ST_WRITE &&
                         opCode == `DCS_OP_WRITE)) begin
                        nxt_burst = `DCS_BURST_CLKS;
                    end else if (!isQuiet(opCode)) begin
                        illegal = 1'b1;
                    end else if (burst_ff <= 3'h1) begin
                        nxt_state = `DCS_ST_ACTIVE;
                    end
                end
                `DCS_ST_REF, `DCS_ST_MRS, `DCS_ST_PRECH: begin
                    // timing is out of scope: one clock then idle
                    if (!isQuiet(opCode)) begin
                        illegal = 1'b1;
                    end
                    nxt_state = `DCS_ST_IDLE;
                end
                default: nxt_state = `DCS_ST_IDLE;
            endcase
        end
    end

    // ------------------------------------------------------------
    // clocked state
    // ------------------------------------------------------------
    always @(posedge clk) begin
        if (reset) begin
            state_ff <= `DCS_ST_IDLE;
            ckePrev_ff <= 1'b1; // idle level: no false cke edge after reset
            rowOpen_ff <= 1'b0;
            burst_ff <= 3'h0;
            ckeHold_ff <= 2'h0;
            xsCount_ff <= 8'h0;
            devState <= `DCS_ST_IDLE;
            illegalCmd <= 1'b0;
            seqError <= 1'b0;
            termActive <= 1'b0;
            wrStrobe <= 1'b0;
            wrDataOut <= 16'h0;
            wrLaneEn <= 2'h0;
            readAllowed <= 1'b1;
        end else if (clkEn) begin
            ckePrev_ff <= cke;
            state_ff <= nxt_state;
            rowOpen_ff <= nxt_rowOpen;
            burst_ff <= nxt_burst;
            devState <= nxt_state;
            illegalCmd <= illegal;
            // cke changed before three edges of registration
            if (cke != ckePrev_ff) begin
                ckeHold_ff <= 2'h1;
                seqError <= seqErr ||
                    (ckeHold_ff != 2'h0 && ckeHold_ff < `DCS_CKE_HOLD);
            end else begin
                seqError <= seqErr;
                if (ckeHold_ff != 2'h0 && ckeHold_ff < `DCS_CKE_HOLD) begin
                    ckeHold_ff <= ckeHold_ff + 2'h1;
                end
            end
            // read lockout after self refresh exit
            if (state_ff == `DCS_ST_SELF_REF && ckeRise) begin
                xsCount_ff <= `DCS_XS_READ_CLKS;
                readAllowed <= 1'b0;
            end else if (xsCount_ff != 8'h0) begin
                xsCount_ff <= xsCount_ff - 8'h1;
                readAllowed <= (xsCount_ff == 8'h1);
            end
            // odt level never enters the state logic
            termActive <= odtEnabled && odt &&
                (nxt_state != `DCS_ST_SELF_REF);
            wrStrobe <= wrBeatValid && (state_ff == `DCS_ST_WRITE);
            wrDataOut <= wrData;
            wrLaneEn <= (wrBeatValid && state_ff == `DCS_ST_WRITE) ?
                ~wrMask : 2'h0;
        end
    end
endmodule

// ===== dcs_state_tracker_properties.sv
// checker for the cke and command state tracker ports
// assumes: bound to dcs_state_tracker; one clock, sync reset
`timescale 1ns/1ps
`include "dcs_consts.vh"
module dcs_state_tracker_properties (
    input wire clk, reset, clkEn, cke, csN, rasN, casN, weN, odt,
    input wire odtEnabled, wrBeatValid, illegalCmd, seqError,
    input wire termActive, wrStrobe, readAllowed,
    input wire [15:0] wrData, wrDataOut,
    input wire [1:0] wrMask, wrLaneEn,
    input wire [3:0] devState
);
reg ckeLast_ff;
wire [3:0] cmd = {csN, rasN, casN, weN};
wire quiet = csN || cmd == 4'h7;
wire hh = clkEn && cke && ckeLast_ff;
wire fall = clkEn && !cke && ckeLast_ff;
always @(posedge clk) begin
    if (reset)
        ckeLast_ff <= 1'b1;
    else if (clkEn)
        ckeLast_ff <= cke;
end
default clocking @(posedge clk); endclocking
default disable iff (reset);
idle_rdwr_a: assert property (hh && devState == `DCS_ST_IDLE &&
    cmd[3:1] == 3'h2 |=> illegalCmd && devState == `DCS_ST_IDLE)
    else $error("read or write taken in idle");
bank_bad_a: assert property (hh && devState == `DCS_ST_ACTIVE &&
    (cmd == 4'h3 || cmd[3:1] == 3'h0) |=> illegalCmd &&
    devState == `DCS_ST_ACTIVE) else $error("bad command in active");
burst_bad_a: assert property (hh && !quiet &&
    (devState == `DCS_ST_READ && cmd != 4'h5 ||
    devState == `DCS_ST_WRITE && cmd != 4'h4) |=> illegalCmd)
    else $error("bad command in burst");
pd_entry_a: assert property (fall && quiet && devState < 4'h2
    |=> devState == ($past(devState) == `DCS_ST_IDLE ?
    `DCS_ST_PRE_PD : `DCS_ST_ACT_PD)) else $error("wrong power down");
sr_entry_a: assert property (fall && cmd == 4'h1 &&
    devState == `DCS_ST_IDLE |=> devState == `DCS_ST_SELF_REF)
    else $error("self refresh missed");
low_hold_a: assert property (clkEn && !cke && !ckeLast_ff &&
    devState inside {4'h4, 4'h5, 4'h6} |=> $stable(devState) &&
    !illegalCmd) else $error("low power state disturbed");
sr_term_a: assert property (
    devState == `DCS_ST_SELF_REF |-> !termActive)
    else $error("termination in self refresh");
write_mask_a: assert property (clkEn && wrBeatValid &&
    devState == `DCS_ST_WRITE |=> wrStrobe && wrDataOut == $past(wrData)
    && wrLaneEn == ~$past(wrMask)) else $error("write beat wrong");
sr_exit_a: assert property (clkEn && cke && !ckeLast_ff &&
    devState == `DCS_ST_SELF_REF |=> devState == `DCS_ST_IDLE &&
    !readAllowed) else $error("self refresh exit wrong");
hold_err_a: assert property (clkEn && cke != ckeLast_ff ##1
    clkEn && cke != ckeLast_ff |=> seqError)
    else $error("short cke hold not flagged");
cover property (fall && cmd == 4'h1);
cover property (wrStrobe && wrLaneEn != 2'h3);
cover property (illegalCmd);
endmodule
bind dcs_state_tracker dcs_state_tracker_properties u_props (
    .clk(clk), .reset(reset), .clkEn(clkEn), .cke(cke), .csN(csN),
    .rasN(rasN), .casN(casN), .weN(weN), .odt(odt),
    .odtEnabled(odtEnabled), .wrBeatValid(wrBeatValid),
    .illegalCmd(illegalCmd), .seqError(seqError),
    .termActive(termActive), .wrStrobe(wrStrobe),
    .readAllowed(readAllowed), .wrData(wrData), .wrDataOut(wrDataOut),
    .wrMask(wrMask), .wrLaneEn(wrLaneEn), .devState(devState));

// ===== ddr2_cke_command_state_rules_test.sv
// self-checking bench for the cke and command state tracker
// assumes: tracker, controller model and checker compiled before it
`timescale 1ns/1ps
`include "dcs_consts.vh"
`define CHK(nm, exp, got) begin check_count++; if ((got) !== (exp)) begin \
    bad_count++; $display("unexpected %s expected %0h seen %0h", \
    nm, exp, got); end end
module ddr2_cke_command_state_rules_test;
reg clk = 1'b0, reset = 1'b1, clkEn = 1'b1, odt = 1'b0, odtEnabled = 1'b0;
reg wrBeatValid = 1'b0, reqCke = 1'b1;
reg [15:0] wrData = 16'h0;
reg [1:0] wrMask = 2'h0;
reg [3:0] reqOp = `DCS_OP_NOP;
wire cke, csN, rasN, casN, weN, illegalCmd, seqError, termActive;
wire wrStrobe, readAllowed;
wire [15:0] wrDataOut;
wire [1:0] wrLaneEn;
wire [3:0] devState;
int bad_count = 0, check_count = 0, n;
// nibbles: operation, cke, expected state (f: not checked), illegal
reg [15:0] rows [0:26] = '{16'h2110, 16'h2111, 16'h6111, 16'h7111,
    16'h4120, 16'h4120, 16'h51f1, 16'h1110, 16'h5130, 16'h5130,
    16'h41f1, 16'h3190, 16'h4101, 16'h5101, 16'h3190, 16'h6170,
    16'h7180, 16'h0100, 16'h1040, 16'h7040, 16'h1100, 16'h2110,
    16'h1050, 16'h4050, 16'h1110, 16'h3190, 16'h0100};
dcs_ctrl_model u_ctrl (.clk(clk), .reqOp(reqOp), .reqCke(reqCke),
    .cke(cke), .csN(csN), .rasN(rasN), .casN(casN), .weN(weN));
dcs_state_tracker DUT (.clk(clk), .reset(reset), .clkEn(clkEn),
    .cke(cke), .csN(csN), .rasN(rasN), .casN(casN), .weN(weN),
    .odt(odt), .odtEnabled(odtEnabled), .wrBeatValid(wrBeatValid),
    .wrData(wrData), .wrMask(wrMask), .devState(devState),
    .illegalCmd(illegalCmd), .seqError(seqError),
    .termActive(termActive), .wrStrobe(wrStrobe),
    .wrDataOut(wrDataOut), .wrLaneEn(wrLaneEn),
    .readAllowed(readAllowed));
initial forever #2.5 clk = ~clk;
task tally_and_finish;
    $display("checks %0d errors %0d", check_count, bad_count);
    if (bad_count == 0 && check_count > 0)
        $display("Finished cleanly");
    else
        $display("Finished with errors");
    $finish;
endtask
// one command, then a nop edge so no request is taken twice
task apply(input [3:0] op, input ck, input [3:0] st, input ill);
    reqOp <= op;
    reqCke <= ck;
    @(posedge clk);
    reqOp <= `DCS_OP_NOP;
    #1;
    if (st != 4'hf) `CHK("devState", st, devState)
    `CHK("illegalCmd", ill, illegalCmd)
    @(posedge clk);
endtask
initial begin
    // run is near 310 cycles; about thirteen times that (4000 cycles) before giving up
    #20000;
    bad_count++;
    tally_and_finish;
end
initial begin
    repeat (20) @(posedge clk);
    reset <= 1'b0;
    @(posedge clk);
    #1 `CHK("rstSeq", 1'b0, seqError)
    @(posedge clk);
    for (int i = 0; i < 27; i++)
        apply(rows[i][15:12], rows[i][8], rows[i][7:4], rows[i][0]);
    apply(`DCS_OP_ACT, 1'b1, `DCS_ST_ACTIVE, 1'b0);
    reqOp <= `DCS_OP_WRITE;
    @(posedge clk);
    reqOp <= `DCS_OP_NOP;
    wrBeatValid <= 1'b1;
    wrData <= 16'ha5c3;
    wrMask <= 2'h1;
    @(posedge clk);
    wrData <= 16'h3c5a;
    wrMask <= 2'h2;
    #1 `CHK("lanes", 2'h2, wrLaneEn)
    `CHK("data", 16'ha5c3, wrDataOut)
    @(posedge clk);
    wrBeatValid <= 1'b0;
    clkEn <= 1'b0;
    reqOp <= `DCS_OP_PRE;
    #1 `CHK("lanes", 2'h1, wrLaneEn)
    `CHK("data", 16'h3c5a, wrDataOut)
    repeat (3) @(posedge clk);
    clkEn <= 1'b1;
    reqOp <= `DCS_OP_NOP;
    odt <= 1'b1;
    odtEnabled <= 1'b1;
    #1 `CHK("frozen", `DCS_ST_ACTIVE, devState)
    @(posedge clk);
    repeat (3) apply(`DCS_OP_NOP, 1'b1, 4'hf, 1'b0);
    apply(`DCS_OP_PRE, 1'b1, `DCS_ST_PRECH, 1'b0);
    apply(`DCS_OP_NOP, 1'b1, `DCS_ST_IDLE, 1'b0);
    #1 `CHK("term", 1'b1, termActive)
    @(posedge clk);
    apply(`DCS_OP_REF, 1'b0, `DCS_ST_SELF_REF, 1'b0);
    apply(`DCS_OP_MRS, 1'b0, `DCS_ST_SELF_REF, 1'b0);
    #1 `CHK("term", 1'b0, termActive)
    @(posedge clk);
    reqCke <= 1'b1;
    n = 0;
    @(posedge clk);
    #1 `CHK("exit", `DCS_ST_IDLE, devState)
    while (readAllowed !== 1'b1 && n < 400) begin
        n++;
        @(posedge clk);
        #1;
    end
    `CHK("readDelay", 200, n)
    @(posedge clk);
    reqCke <= 1'b0;
    @(posedge clk);
    reqCke <= 1'b1;
    @(posedge clk);
    #1 `CHK("seqError", 1'b1, seqError)
    @(posedge clk);
    reset <= 1'b1;
    repeat (2) @(posedge clk);
    reset <= 1'b0;
    #1 `CHK("rstState", `DCS_ST_IDLE, devState)
    `CHK("rstRead", 1'b1, readAllowed)
    tally_and_finish;
end
endmodule
